// ==== hdl/dms_drive_seq.sv ====
// drive mode sequencer: auto setup, test run and special drive modes
// ----------------------------------------------------------------
// Notes on behaviour
// - auto setup starts only when operation enabled
// - status bit 12 set when auto setup completes or fails, not on abort
// - status bit 10 shows whether index found
// - successful setup stores categories 05 and 06
// - control word value 6 stops the motor
// - config key 2 enables special modes, disables bus
// - special modes: state follows enable input only
// - digital input 1 is the enable
// - switch bit 3 picks closed loop
// - switch picks clock-direction or 30 rpm tests
// - analog speed with direction input, 1000/100 rpm
// - joystick analog speed, 1000/100 rpm
// - switch sampled only at restart
// - clock-direction mode set internally, steps pass
// - analog mode writes velocity setpoint internally
// - maximum speed selectable 100 or 1000 rpm
// - full scale gives maximum, direction from input
// - below 20 mV the motor stands still
// - joystick: midpoint zero, 20 mV dead band
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module dms_drive_seq (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] special_mode_config_key,
   input wire logic [3:0] mode_select_switch,
   input wire logic obj_wr,
   input wire logic obj_rd,
   input wire logic [15:0] obj_index,
   input wire logic [15:0] obj_wdata,
   output logic [15:0] obj_rdata,
   output logic obj_ack,
   output logic obj_err,
   input wire logic enable_in,
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic [11:0] analog_code,
   input wire logic meas_done,
   input wire logic meas_ok,
   input wire logic meas_index,
   output logic canopen_en,
   output logic op_enabled,
   output logic closed_loop,
   output logic [7:0] active_mode,
   output logic signed [15:0] target_vel,
   output logic setup_run,
   output logic store_req,
   output logic [7:0] store_cat,
   output logic step_out,
   output logic dir_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sampled;
      logic special;
      dms_pkg::dms_kind_t kind;
      logic closed;
      logic max_hi;
      logic [15:0] cw;
      logic [7:0] mode;
      logic [15:0] vel;
      logic op_en;
      dms_pkg::dms_as_t as_st;
      logic run;
      logic done;
      logic index;
      logic store_req;
      logic [7:0] store_cat;
      logic [15:0] rdata;
      logic ack;
      logic err;
      logic step;
      logic dir;
      logic [7:0] mode_code;
      logic can_en;
   } dms_state_t;

   dms_state_t st_ff;
   dms_state_t nxt_st;
   dms_pkg::dms_kind_t dec_kind;
   logic dec_closed;
   logic dec_max_hi;
   logic signed [15:0] ana_speed;
   logic [15:0] status_word;
   logic cw_wr;
   logic mode_specific_rise;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   dms_switch_decode u_decode (
      .mode_select_switch(mode_select_switch),
      .kind(dec_kind),
      .closed_loop(dec_closed),
      .max_hi(dec_max_hi)
   );

   dms_analog_speed u_analog (
      .core_clk(core_clk),
      .rst(rst),
      .analog_code(analog_code),
      .joystick(st_ff.kind == dms_pkg::KIND_ANA_JOY),
      .max_hi(st_ff.max_hi),
      .dir_ccw(dir_in),
      .speed(ana_speed)
   );

   always_comb begin
      status_word = dms_pkg::SW_RESET;
      status_word[dms_pkg::SW_SETUP_DONE_BIT] = st_ff.done;
      status_word[dms_pkg::SW_TARGET_REACHED_BIT] = st_ff.index;
      status_word[dms_pkg::SW_OP_ENABLED_BIT] = st_ff.op_en;
   end

   assign cw_wr = obj_wr && st_ff.can_en && obj_index == dms_pkg::IDX_CTRL;
   assign mode_specific_rise = cw_wr && obj_wdata[dms_pkg::CW_MODE_SPECIFIC_BIT] &&
                               !st_ff.cw[dms_pkg::CW_MODE_SPECIFIC_BIT];

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.store_req = 1'b0;
      nxt_st.ack = 1'b0;
      nxt_st.err = 1'b0;

      // restart capture of key and switch, once only
      if (!st_ff.sampled) begin
         nxt_st.sampled = 1'b1;
         nxt_st.special = special_mode_config_key == dms_pkg::SPECIAL_KEY_ON;
         nxt_st.kind = dec_kind;
         nxt_st.closed = dec_closed;
         nxt_st.max_hi = dec_max_hi;
      end
      nxt_st.can_en = nxt_st.sampled && !nxt_st.special;

      // object access; refused while the bus is off
      if (obj_wr || obj_rd) begin
         nxt_st.ack = 1'b1;
         if (!st_ff.can_en) begin
            nxt_st.err = 1'b1;
         end else if (obj_wr) begin
            unique case (obj_index)
               dms_pkg::IDX_CTRL: nxt_st.cw = obj_wdata;
               dms_pkg::IDX_VEL: nxt_st.vel = obj_wdata;
               dms_pkg::IDX_MODE: nxt_st.mode = obj_wdata[7:0];
               default: nxt_st.err = 1'b1;
            endcase
         end else begin
            unique case (obj_index)
               dms_pkg::IDX_CTRL: nxt_st.rdata = st_ff.cw;
               dms_pkg::IDX_STAT: nxt_st.rdata = status_word;
               dms_pkg::IDX_VEL: nxt_st.rdata = st_ff.vel;
               dms_pkg::IDX_MODE: nxt_st.rdata = {8'h00, st_ff.mode};
               default: begin
                  nxt_st.rdata = 16'h0000;
                  nxt_st.err = 1'b1;
               end
            endcase
         end
      end

      // power state
      if (st_ff.special) begin
         nxt_st.op_en = enable_in;
      end else if (cw_wr && obj_wdata == dms_pkg::CW_STOP) begin
         nxt_st.op_en = 1'b0;
      end else if (cw_wr && obj_wdata == dms_pkg::CW_ENABLE) begin
         nxt_st.op_en = 1'b1;
      end

      // auto setup sequence
      unique case (st_ff.as_st)
         dms_pkg::AS_IDLE: begin
            if (mode_specific_rise && st_ff.op_en && st_ff.mode == dms_pkg::MODE_AUTOSETUP) begin
               nxt_st.as_st = dms_pkg::AS_RUN;
               nxt_st.done = 1'b0;
            end
         end
         dms_pkg::AS_RUN: begin
            if (!st_ff.op_en || st_ff.special) begin
               nxt_st.as_st = dms_pkg::AS_IDLE;
            end else if (meas_done) begin
               nxt_st.index = meas_index;
               if (meas_ok) begin
                  nxt_st.as_st = dms_pkg::AS_STORE;
                  nxt_st.store_req = 1'b1;
                  nxt_st.store_cat = dms_pkg::STORE_CAT_DRIVE;
               end else begin
                  nxt_st.as_st = dms_pkg::AS_IDLE;
                  nxt_st.done = 1'b1;
               end
            end
         end
         dms_pkg::AS_STORE: begin
            nxt_st.as_st = dms_pkg::AS_IDLE;
            nxt_st.store_req = 1'b1;
            nxt_st.store_cat = dms_pkg::STORE_CAT_TUNING;
            nxt_st.done = 1'b1;
         end
         default: nxt_st.as_st = dms_pkg::AS_IDLE;
      endcase
      nxt_st.run = nxt_st.as_st == dms_pkg::AS_RUN;

      // special drive modes set mode and speed internally
      nxt_st.step = 1'b0;
      nxt_st.dir = dir_in;
      nxt_st.mode_code = st_ff.mode;
      if (st_ff.special) begin
         nxt_st.mode_code = dms_pkg::MODE_VELOCITY;
         unique case (st_ff.kind)
            dms_pkg::KIND_CLKDIR: begin
               nxt_st.mode_code = dms_pkg::MODE_CLKDIR;
               nxt_st.step = st_ff.op_en && step_in;
               nxt_st.vel = 16'h0000;
            end
            dms_pkg::KIND_TEST_CW: nxt_st.vel = st_ff.op_en ? dms_pkg::TEST_RPM : 16'sh0000;
            dms_pkg::KIND_TEST_CCW: nxt_st.vel = st_ff.op_en ? -dms_pkg::TEST_RPM : 16'sh0000;
            default: nxt_st.vel = st_ff.op_en ? ana_speed : 16'sh0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign obj_rdata = st_ff.rdata;
   assign obj_ack = st_ff.ack;
   assign obj_err = st_ff.err;
   assign canopen_en = st_ff.can_en;
   assign op_enabled = st_ff.op_en;
   assign closed_loop = st_ff.closed;
   assign active_mode = st_ff.mode_code;
   assign target_vel = st_ff.vel;
   assign setup_run = st_ff.run;
   assign store_req = st_ff.store_req;
   assign store_cat = st_ff.store_cat;
   assign step_out = st_ff.step;
   assign dir_out = st_ff.dir;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   enable_follow_a: assert property (st_ff.special |=> op_enabled == $past(enable_in))
      else $error("power state does not follow enable input");
   ctrl_ignored_a: assert property (st_ff.special && obj_wr |=> obj_err && op_enabled == $past(enable_in))
      else $error("control write acted in special mode");
   stop_word_a: assert property (!st_ff.special && cw_wr && obj_wdata == dms_pkg::CW_STOP |=> !op_enabled)
      else $error("stop word did not disable drive");
   setup_start_a: assert property ($rose(setup_run) |->
      $past(st_ff.op_en) && $past(st_ff.mode) == dms_pkg::MODE_AUTOSETUP && $past(mode_specific_rise))
      else $error("auto setup started without its preconditions");
   setup_done_a: assert property (setup_run && meas_done && meas_ok && op_enabled && !st_ff.special |->
      ##2 status_word[dms_pkg::SW_SETUP_DONE_BIT] && !setup_run)
      else $error("done bit not set after auto setup");
   store_seq_a: assert property (setup_run && meas_done && meas_ok && op_enabled && !st_ff.special |=>
      store_req && store_cat == dms_pkg::STORE_CAT_DRIVE ##1
      store_req && store_cat == dms_pkg::STORE_CAT_TUNING ##1 !store_req)
      else $error("store categories not issued in order");
   index_bit_a: assert property (setup_run && meas_done && op_enabled && !st_ff.special |=>
      status_word[dms_pkg::SW_TARGET_REACHED_BIT] == $past(meas_index))
      else $error("index bit does not match measurement");
   switch_once_a: assert property (st_ff.sampled |=> $stable(st_ff.kind) && $stable(closed_loop))
      else $error("switch decode changed after restart");
   key_off_a: assert property ($rose(st_ff.sampled) |->
      canopen_en == ($past(special_mode_config_key) != dms_pkg::SPECIAL_KEY_ON))
      else $error("bus enable does not match config key");
   test_cw_a: assert property (st_ff.special && st_ff.kind == dms_pkg::KIND_TEST_CW && op_enabled |=>
      target_vel == dms_pkg::TEST_RPM)
      else $error("test run speed wrong");

   // special drive mode outputs
   test_ccw_a: assert property (st_ff.special && st_ff.kind == dms_pkg::KIND_TEST_CCW && op_enabled |=>
      target_vel == -dms_pkg::TEST_RPM)
      else $error("reverse test run speed wrong");

   step_pass_a: assert property (st_ff.special && st_ff.kind == dms_pkg::KIND_CLKDIR |=>
      step_out == ($past(op_enabled) && $past(step_in)))
      else $error("step input not passed through");

   dir_follow_a: assert property (1'b1 |=> dir_out == $past(dir_in))
      else $error("direction output does not follow input");

   speed_gate_a: assert property (st_ff.special && !op_enabled |=> target_vel == 16'sh0000)
      else $error("speed set while enable input low");

   clkdir_mode_a: assert property (st_ff.special && st_ff.kind == dms_pkg::KIND_CLKDIR |=>
      active_mode == dms_pkg::MODE_CLKDIR)
      else $error("clock-direction mode not set");

   velocity_mode_a: assert property (st_ff.special && (st_ff.kind == dms_pkg::KIND_ANA_DIR ||
      st_ff.kind == dms_pkg::KIND_ANA_JOY) |=> active_mode == dms_pkg::MODE_VELOCITY)
      else $error("velocity mode not set for analog speed");

   // bus access and loop select
   bus_mode_a: assert property (!st_ff.special |=> active_mode == $past(st_ff.mode))
      else $error("mode register not shown in bus mode");

   bus_refuse_a: assert property (!canopen_en && (obj_wr || obj_rd) |=> obj_ack && obj_err)
      else $error("access not refused while bus is off");

   loop_bit_a: assert property ($rose(st_ff.sampled) |->
      closed_loop == $past(mode_select_switch[dms_pkg::SWITCH_LOOP_BIT]))
      else $error("loop select does not match switch");

   // auto setup endings
   setup_fail_a: assert property (setup_run && meas_done && !meas_ok && op_enabled && !st_ff.special |=>
      !store_req && status_word[dms_pkg::SW_SETUP_DONE_BIT] && !setup_run)
      else $error("failed auto setup not ended cleanly");

   setup_abort_a: assert property (setup_run && !op_enabled |=> !setup_run)
      else $error("auto setup not aborted when disabled");

   setup_ok_c: cover property (store_req && store_cat == dms_pkg::STORE_CAT_TUNING);
   setup_fail_c: cover property (setup_run && meas_done && !meas_ok);
   step_seen_c: cover property (step_out);
   analog_run_c: cover property (st_ff.special && st_ff.kind == dms_pkg::KIND_ANA_JOY && target_vel < 16'sh0000);
   stop_c: cover property (!st_ff.special && cw_wr && obj_wdata == dms_pkg::CW_STOP && op_enabled);
endmodule
`default_nettype wire

// ==== hdl/dms_pkg.sv ====
// shared constants and types of the drive mode sequencer
package dms_pkg;
   // object dictionary indices
   localparam logic [15:0] IDX_CTRL = 16'h6040;
   localparam logic [15:0] IDX_STAT = 16'h6041;
   localparam logic [15:0] IDX_VEL = 16'h6042;
   localparam logic [15:0] IDX_MODE = 16'h6060;
   // operating mode codes
   localparam logic [7:0] MODE_AUTOSETUP = 8'hfe;
   localparam logic [7:0] MODE_VELOCITY = 8'h02;
   localparam logic [7:0] MODE_CLKDIR = 8'hf0;
   // control and status word layout
   localparam int CW_MODE_SPECIFIC_BIT = 4;
   localparam int SW_SETUP_DONE_BIT = 12;
   localparam int SW_TARGET_REACHED_BIT = 10;
   localparam int SW_OP_ENABLED_BIT = 2;
   localparam logic [15:0] CW_STOP = 16'h0006;
   localparam logic [15:0] CW_ENABLE = 16'h000f;
   localparam logic [15:0] SW_RESET = 16'h0000;
   // restart configuration
   localparam logic [7:0] SPECIAL_KEY_ON = 8'h02;
   localparam int SWITCH_LOOP_BIT = 3;
   // store categories
   localparam logic [7:0] STORE_CAT_DRIVE = 8'h05;
   localparam logic [7:0] STORE_CAT_TUNING = 8'h06;
   // speeds in rpm
   localparam logic signed [15:0] TEST_RPM = 16'sh001e;
   localparam logic [15:0] MAX_HI_RPM = 16'h03e8;
   localparam logic [15:0] MAX_LO_RPM = 16'h0064;
   // analog input scaling
   localparam int FULL_MV = 10000;
   localparam int DEAD_MV = 20;
   localparam int ADC_FULL_INT = 4095;
   localparam int DEAD_CNT_INT = (DEAD_MV * ADC_FULL_INT + FULL_MV - 1) / FULL_MV;
   localparam logic [11:0] ADC_FULL = 12'(ADC_FULL_INT);
   localparam logic [11:0] ADC_MID = 12'(ADC_FULL_INT / 2);
   localparam logic [11:0] DEAD_CNT = 12'(DEAD_CNT_INT);

   typedef enum logic [2:0] {
      KIND_CLKDIR, KIND_TEST_CW, KIND_TEST_CCW, KIND_ANA_DIR, KIND_ANA_JOY
   } dms_kind_t;

   typedef enum logic [1:0] {AS_IDLE, AS_RUN, AS_STORE} dms_as_t;
endpackage

// ==== hdl/dms_switch_decode.sv ====
// decode of the mode select switch into special drive mode fields
`timescale 1ns/10ps
`default_nettype none
module dms_switch_decode (
   input wire logic [3:0] mode_select_switch,
   output dms_pkg::dms_kind_t kind,
   output logic closed_loop,
   output logic max_hi
);
   always_comb begin
      closed_loop = mode_select_switch[dms_pkg::SWITCH_LOOP_BIT];
      max_hi = !mode_select_switch[0];
      unique case (mode_select_switch[2:1])
         2'h0: kind = dms_pkg::KIND_CLKDIR;
         2'h1: kind = mode_select_switch[0] ? dms_pkg::KIND_TEST_CCW : dms_pkg::KIND_TEST_CW;
         2'h2: kind = dms_pkg::KIND_ANA_DIR;
         2'h3: kind = dms_pkg::KIND_ANA_JOY;
      endcase
   end
endmodule
`default_nettype wire

// ==== hdl/dms_analog_speed.sv ====
// analog input to signed target speed conversion
`timescale 1ns/10ps
`default_nettype none
module dms_analog_speed (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [11:0] analog_code,
   input wire logic joystick,
   input wire logic max_hi,
   input wire logic dir_ccw,
   output logic signed [15:0] speed
);
   typedef struct packed {
      logic signed [15:0] speed;
   } dms_ana_state_t;

   dms_ana_state_t st_ff;
   dms_ana_state_t nxt_st;
   logic [11:0] mag;
   logic [11:0] span;
   logic neg;
   logic [27:0] prod;
   logic [27:0] quot;

   always_comb begin
      mag = 12'h000;
      span = 12'h001;
      neg = 1'b0;
      if (joystick) begin
         // zero speed at midpoint, dead band either side
         if (analog_code > dms_pkg::ADC_MID + dms_pkg::DEAD_CNT) begin
            mag = analog_code - dms_pkg::ADC_MID - dms_pkg::DEAD_CNT;
            span = dms_pkg::ADC_FULL - dms_pkg::ADC_MID - dms_pkg::DEAD_CNT;
         end else if (analog_code < dms_pkg::ADC_MID - dms_pkg::DEAD_CNT) begin
            mag = dms_pkg::ADC_MID - dms_pkg::DEAD_CNT - analog_code;
            span = dms_pkg::ADC_MID - dms_pkg::DEAD_CNT;
            neg = 1'b1;
         end
      end else if (analog_code > dms_pkg::DEAD_CNT) begin
         mag = analog_code - dms_pkg::DEAD_CNT;
         span = dms_pkg::ADC_FULL - dms_pkg::DEAD_CNT;
         neg = dir_ccw;
      end
      prod = 28'(mag) * 28'(max_hi ? dms_pkg::MAX_HI_RPM : dms_pkg::MAX_LO_RPM);
      quot = prod / 28'(span);
      nxt_st.speed = neg ? -signed'(quot[15:0]) : signed'(quot[15:0]);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign speed = st_ff.speed;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   dead_zone_a: assert property (!joystick && analog_code <= dms_pkg::DEAD_CNT |=> speed == 16'sh0000)
      else $error("speed not zero inside dead zone");
   full_scale_a: assert property (!joystick && analog_code == dms_pkg::ADC_FULL && !dir_ccw |=>
      speed == signed'($past(max_hi) ? dms_pkg::MAX_HI_RPM : dms_pkg::MAX_LO_RPM))
      else $error("full scale does not give maximum speed");
endmodule
`default_nettype wire

// ==== test/dms_master_model.sv ====
// bus master model issuing object accesses to the drive sequencer
`timescale 1ns/10ps
`default_nettype none
module dms_master_model (
   input wire logic core_clk,
   output var logic obj_wr,
   output var logic obj_rd,
   output var logic [15:0] obj_index,
   output var logic [15:0] obj_wdata,
   input wire logic [15:0] obj_rdata,
   input wire logic obj_ack,
   input wire logic obj_err
);
   initial begin
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      obj_index = 16'h0000;
      obj_wdata = 16'h0000;
   end

   // ----------------------------------------------------------------
   // single object access
   // ----------------------------------------------------------------
   task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                         output logic [15:0] rd, output logic err, output logic ok);
      ok = 1'b0;
      rd = 16'h0000;
      err = 1'b0;
      @(posedge core_clk);
      #10;
      obj_wr = wr;
      obj_rd = ~wr;
      obj_index = idx;
      obj_wdata = wd;
      @(posedge core_clk);
      #10;
      obj_wr = 1'b0;
      obj_rd = 1'b0;
      // released lines carry the inverse so stale values never look valid
      obj_index = ~idx;
      obj_wdata = ~wd;
      for (int n = 0; n < 4; n++) begin
         if (!ok && obj_ack === 1'b1) begin
            ok = 1'b1;
            rd = obj_rdata;
            err = obj_err;
         end
         if (!ok) begin
            @(posedge core_clk);
            #10;
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== test/dms_drive_seq_tb.sv ====
// self-checking bench of the drive mode sequencer
`timescale 1ns/10ps
`default_nettype none
module dms_drive_seq_tb;
   typedef struct packed {
      logic [3:0] sw;
      logic dir;
      logic [11:0] code;
      logic [7:0] mode;
      logic [15:0] vel;
   } dms_row_t;

   logic core_clk, rst, obj_wr, obj_rd, obj_ack, obj_err, enable_in, step_in, dir_in;
   logic meas_done, meas_ok, meas_index, canopen_en, op_enabled, closed_loop, setup_run;
   logic store_req, step_out, dir_out, ok, err;
   logic [7:0] key, active_mode, store_cat;
   logic [3:0] sw;
   logic [11:0] analog_code;
   logic [15:0] obj_index, obj_wdata, obj_rdata, rd_val;
   logic signed [15:0] target_vel;
   int fail_count = 0;
   int samples_checked = 0;
   dms_row_t rows [19];

   dms_drive_seq dut_u (
      .core_clk, .rst, .special_mode_config_key(key), .mode_select_switch(sw),
      .obj_wr, .obj_rd, .obj_index, .obj_wdata, .obj_rdata, .obj_ack, .obj_err,
      .enable_in, .step_in, .dir_in, .analog_code, .meas_done, .meas_ok, .meas_index,
      .canopen_en, .op_enabled, .closed_loop, .active_mode, .target_vel, .setup_run,
      .store_req, .store_cat, .step_out, .dir_out
   );

   dms_master_model master_u (
      .core_clk, .obj_wr, .obj_rd, .obj_index, .obj_wdata, .obj_rdata, .obj_ack, .obj_err
   );

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      chk16(what, {15'h0000, exp}, {15'h0000, got});
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask

   task automatic restart(input logic [7:0] k, input logic [3:0] s);
      tick(1);
      rst = 1'b1;
      key = k;
      sw = s;
      tick(2);
      rst = 1'b0;
      tick(6);
   endtask

   task automatic acc(input logic wr, input logic [15:0] idx, input logic [15:0] wd, input logic exp_err);
      master_u.access(wr, idx, wd, rd_val, err, ok);
      chk1("obj ack", 1'b1, ok);
      chk1("obj err", exp_err, err);
      if (ok !== 1'b1) begin
         conclude();
      end
   endtask

   task automatic measure(input logic good, input logic idx);
      meas_done = 1'b1;
      meas_ok = good;
      meas_index = idx;
      tick(1);
      meas_done = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      key = 8'h00;
      sw = 4'h0;
      enable_in = 1'b0;
      step_in = 1'b0;
      dir_in = 1'b0;
      analog_code = 12'h000;
      meas_done = 1'b0;
      meas_ok = 1'b0;
      meas_index = 1'b0;
      rows = '{
         {4'h0, 1'b0, 12'h000, 8'hf0, 16'h0000}, {4'h1, 1'b0, 12'h000, 8'hf0, 16'h0000},
         {4'h2, 1'b0, 12'h000, 8'h00, 16'h001e}, {4'h3, 1'b0, 12'h000, 8'h00, 16'hffe2},
         {4'h4, 1'b0, 12'hfff, 8'h02, 16'h03e8}, {4'h4, 1'b1, 12'hfff, 8'h02, 16'hfc18},
         {4'h5, 1'b1, 12'hfff, 8'h02, 16'hff9c}, {4'h6, 1'b0, 12'h7ff, 8'h02, 16'h0000},
         {4'h6, 1'b0, 12'hfff, 8'h02, 16'h03e8}, {4'h7, 1'b0, 12'h000, 8'h02, 16'hff9c},
         {4'h8, 1'b0, 12'h000, 8'hf0, 16'h0000}, {4'h9, 1'b0, 12'h000, 8'hf0, 16'h0000},
         {4'ha, 1'b0, 12'h000, 8'h00, 16'h001e}, {4'hb, 1'b0, 12'h000, 8'h00, 16'hffe2},
         {4'hc, 1'b0, 12'h009, 8'h02, 16'h0000}, {4'hd, 1'b0, 12'hfff, 8'h02, 16'h0064},
         {4'he, 1'b0, 12'h000, 8'h02, 16'hfc18}, {4'he, 1'b0, 12'h808, 8'h02, 16'h0000},
         {4'hf, 1'b0, 12'hfff, 8'h02, 16'h0064}};
      foreach (rows[i]) begin
         enable_in = 1'b1;
         dir_in = rows[i].dir;
         analog_code = rows[i].code;
         restart(8'h02, rows[i].sw);
         chk1("bus enable", 1'b0, canopen_en);
         chk1("power state", 1'b1, op_enabled);
         chk1("loop select", rows[i].sw[3], closed_loop);
         if (rows[i].mode != 8'h00) chk16("mode", {8'h00, rows[i].mode}, {8'h00, active_mode});
         if (rows[i].mode != 8'hf0) chk16("speed", rows[i].vel, target_vel);
      end
      // clock-direction pass-through, late switch move, ignored control writes
      restart(8'h02, 4'h9);
      step_in = 1'b1;
      dir_in = 1'b1;
      sw = 4'h4;
      tick(1);
      chk1("step out", 1'b1, step_out);
      chk1("dir out", 1'b1, dir_out);
      tick(3);
      chk16("mode after switch move", 16'h00f0, {8'h00, active_mode});
      chk1("loop after switch move", 1'b1, closed_loop);
      acc(1'b1, 16'h6040, 16'h0006, 1'b1);
      chk1("power state", 1'b1, op_enabled);
      enable_in = 1'b0;
      tick(1);
      chk1("power off", 1'b0, op_enabled);
      tick(1);
      chk1("step gated", 1'b0, step_out);
      // bus mode: refusals, auto setup success, failure and abort, velocity run
      restart(8'h00, 4'h0);
      chk1("bus enable", 1'b1, canopen_en);
      acc(1'b1, 16'h1234, 16'h0000, 1'b1);
      acc(1'b1, 16'h6041, 16'hffff, 1'b1);
      acc(1'b1, 16'h6060, 16'h00fe, 1'b0);
      acc(1'b0, 16'h6060, 16'h0000, 1'b0);
      chk16("mode readback", 16'h00fe, rd_val);
      acc(1'b1, 16'h6040, 16'h0016, 1'b0);
      chk1("setup held off", 1'b0, setup_run);
      acc(1'b1, 16'h6040, 16'h0006, 1'b0);
      acc(1'b1, 16'h6040, 16'h000f, 1'b0);
      chk1("enabled", 1'b1, op_enabled);
      acc(1'b1, 16'h6040, 16'h001f, 1'b0);
      chk1("setup running", 1'b1, setup_run);
      measure(1'b1, 1'b1);
      chk1("store first", 1'b1, store_req);
      chk16("store cat", 16'h0005, {8'h00, store_cat});
      tick(1);
      chk1("store second", 1'b1, store_req);
      chk16("store cat", 16'h0006, {8'h00, store_cat});
      tick(1);
      chk1("store ended", 1'b0, store_req);
      acc(1'b0, 16'h6041, 16'h0000, 1'b0);
      chk16("status done", 16'h1404, rd_val & 16'h1404);
      acc(1'b1, 16'h6040, 16'h000f, 1'b0);
      acc(1'b1, 16'h6040, 16'h001f, 1'b0);
      acc(1'b0, 16'h6041, 16'h0000, 1'b0);
      chk16("status running", 16'h0004, rd_val & 16'h1004);
      measure(1'b0, 1'b0);
      chk1("no store", 1'b0, store_req);
      acc(1'b0, 16'h6041, 16'h0000, 1'b0);
      chk16("status failed", 16'h1004, rd_val & 16'h1404);
      acc(1'b1, 16'h6040, 16'h000f, 1'b0);
      acc(1'b1, 16'h6040, 16'h001f, 1'b0);
      chk1("setup restarted", 1'b1, setup_run);
      acc(1'b1, 16'h6040, 16'h0006, 1'b0);
      tick(1);
      chk1("setup aborted", 1'b0, setup_run);
      acc(1'b0, 16'h6041, 16'h0000, 1'b0);
      chk16("status aborted", 16'h0000, rd_val & 16'h1004);
      acc(1'b1, 16'h6040, 16'h000f, 1'b0);
      acc(1'b1, 16'h6060, 16'h0002, 1'b0);
      acc(1'b1, 16'h6042, 16'h00c8, 1'b0);
      tick(2);
      chk16("mode", 16'h0002, {8'h00, active_mode});
      chk16("speed", 16'h00c8, target_vel);
      acc(1'b1, 16'h6040, 16'h0006, 1'b0);
      chk1("stopped", 1'b0, op_enabled);
      conclude();
   end
endmodule
`default_nettype wire
